// ==== rtl/dram_init_pkg.sv ====
// constants for the dram power-up and initialization tracker
// assumes a 20 MHz core clock; pin timing is sampled, not edge-clocked
package dram_init_pkg;
   // ==========================================
   // clock and calibration timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int CAL_TIME_NS   = 1000;   // calibration_time, least
   localparam int CAL_CYCLES    = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CAL_CNT_W     = 5;

   // ==========================================
   // command headers on the first beat, ca[4:0]
   localparam logic [4:0] HDR_MPC  = 5'h00;
   localparam logic [4:0] HDR_WR1  = 5'h04;
   localparam logic [4:0] HDR_MWR1 = 5'h0C;
   localparam logic [4:0] HDR_RD1  = 5'h02;
   localparam logic [4:0] HDR_MRW1 = 5'h06;
   localparam logic [4:0] HDR_MRW2 = 5'h16;

   // multipurpose opcodes (seven bits)
   localparam logic [6:0] MPC_CAL_START = 7'h4F;
   localparam logic [6:0] MPC_CAL_LATCH = 7'h51;
   localparam logic [6:0] MPC_FIFO_WR   = 7'h47;
   localparam logic [6:0] MPC_FIFO_RD   = 7'h41;
   localparam logic [6:0] MPC_RD_CAL    = 7'h43;

   // ==========================================
   // mode register addresses and table index
   localparam logic [5:0] MA_RECOVERY = 6'h01;
   localparam logic [5:0] MA_LATENCY  = 6'h02;
   localparam logic [5:0] MA_INVERT   = 6'h03;
   localparam logic [5:0] MA_TERM     = 6'h0B;
   localparam logic [5:0] MA_CMD_REF  = 6'h0C;
   localparam logic [5:0] MA_SETPOINT = 6'h0D;
   localparam logic [5:0] MA_DQ_REF   = 6'h0E;
   localparam int         MR_COUNT    = 7;

   // values after reset, in index order
   localparam logic [7:0] RST_RECOVERY = 8'h00;
   localparam logic [7:0] RST_LATENCY  = 8'h00;
   localparam logic [7:0] RST_INVERT   = 8'h00;
   localparam logic [7:0] RST_TERM     = 8'h00;
   localparam logic [7:0] RST_CMD_REF  = 8'h4D;
   localparam logic [7:0] RST_SETPOINT = 8'h00;
   localparam logic [7:0] RST_DQ_REF   = 8'h4D;

   // field positions
   localparam int LAT_WLEV_BIT = 7;
   localparam int LAT_WLS_BIT  = 6;
   localparam int LAT_WL_LSB   = 3;
   localparam int RCV_NWR_LSB  = 4;
   localparam int INV_LSB      = 6;
   localparam int TERM_CA_LSB  = 4;
   localparam int REF_RANGE    = 6;
   localparam int SP_FSP_LSB   = 6;
   localparam int SP_CBT_BIT   = 0;

   // command decoder states
   typedef enum logic [0:0] {
      ST_HDR = 1'b0,
      ST_ARG = 1'b1
   } beat_t;
endpackage : dram_init_pkg

// ==== rtl/dram_init_tracker.sv ====
// device-side power-up, mode register and training state of the dram
// assumes all pin inputs are asynchronous to clk and ck runs far slower
// What this block does
// - reset selects latency set 0, write latency 0, read latency 0, recovery 0
// - reset clears bus inversion and both termination fields to zero
// - reset sets command reference to range 1, code 001101
// - reset sets data reference to range 1, code 001101
// - the data bus stays high impedance (dq_oe_b high) while the reset pin is low
// - calibration latch, 1 us after start, applies the calibrated code
// - a mode write enters command bus training; ca patterns are captured
// - training results leave on the data bus, not clock aligned
// - latency register bit 7 set enters write leveling
// - read calibration and training buffer commands never touch the array
// - once running, the device accepts any valid command
`timescale 1ns/1ps
`default_nettype none
module dram_init_tracker #(
   parameter int DQ_W = 8,
   parameter int CAL_W = 6
) (
   // core clock and reset
   input  wire logic               clk,
   input  wire logic               rst_b,
   // dram pins from the controller
   input  wire logic               reset_pin_b,
   input  wire logic               dram_ck,
   input  wire logic               cke,
   input  wire logic               cs,
   input  wire logic [5:0]         ca,
   // calibration engine result
   input  wire logic [CAL_W-1:0]   cal_code,
   // data bus drive
   output logic [DQ_W-1:0]         dq_out,
   output logic                    dq_oe_b,
   // configuration seen by the core
   output logic                    write_latency_set,
   output logic [2:0]              write_latency,
   output logic [2:0]              read_latency,
   output logic [2:0]              write_recovery_cycles,
   output logic [1:0]              bus_inversion_enable,
   output logic [2:0]              ca_on_die_termination,
   output logic [2:0]              dq_on_die_termination,
   output logic [6:0]              cmd_reference_level,
   output logic [6:0]              dq_reference_level,
   output logic [1:0]              frequency_set_point_select,
   // status
   output logic                    cbt_active,
   output logic                    write_level_active,
   output logic                    cal_busy,
   output logic                    cal_applied,
   output logic [CAL_W-1:0]        drive_cal_code,
   output logic                    accept_ready,
   output logic                    array_cmd,
   output logic                    train_fifo_wr,
   output logic                    train_fifo_rd,
   output logic                    train_rd_cal
);
   // ==========================================
   // pin synchronisers
   logic       rstp_s1_ff, rstp_s2_ff, cke_s1_ff, cke_s2_ff, cs_s1_ff, cs_s2_ff;
   logic       ck_s1_ff, ck_s2_ff, ck_s3_ff;
   logic [5:0] ca_s1_ff, ca_s2_ff;

   // two flops on every pin, third ck flop for edge finding
   always_ff @(posedge clk) begin
      {rstp_s1_ff, rstp_s2_ff} <= {reset_pin_b, rstp_s1_ff};
      {cke_s1_ff, cke_s2_ff}   <= {cke, cke_s1_ff};
      {cs_s1_ff, cs_s2_ff}     <= {cs, cs_s1_ff};
      {ck_s1_ff, ck_s2_ff}     <= {dram_ck, ck_s1_ff};
      ck_s3_ff                 <= ck_s2_ff;
      ca_s1_ff                 <= ca;
      ca_s2_ff                 <= ca_s1_ff;
   end

   // ==========================================
   // command decode
   dram_init_pkg::beat_t beat_ff, nxt_beat;
   logic [4:0] hdr_ff;
   logic       op7_ff, hdr_op6_ff;
   logic [5:0] ma_ff;
   wire hold_rst = !rst_b || !rstp_s2_ff;
   wire ck_rise  = ck_s2_ff && !ck_s3_ff;
   wire sample   = ck_rise && cke_s2_ff && !hold_rst;
   wire hdr_go   = sample && cs_s2_ff && (beat_ff == dram_init_pkg::ST_HDR);
   wire arg_go   = sample && (beat_ff == dram_init_pkg::ST_ARG);
   wire [6:0] mpc_op  = {op7_ff, ca_s2_ff};
   wire mpc_go   = arg_go && (hdr_ff == dram_init_pkg::HDR_MPC);
   wire mrw1_go  = arg_go && (hdr_ff == dram_init_pkg::HDR_MRW1);
   wire mrw2_go  = arg_go && (hdr_ff == dram_init_pkg::HDR_MRW2);
   wire [7:0] mrw_data = {op7_ff, hdr_op6_ff, ca_s2_ff};
   wire array_go = arg_go && (hdr_ff[0] || hdr_ff == dram_init_pkg::HDR_WR1
                  || hdr_ff == dram_init_pkg::HDR_MWR1 || hdr_ff == dram_init_pkg::HDR_RD1);
   wire cal_start_go = mpc_go && (mpc_op == dram_init_pkg::MPC_CAL_START);
   wire cal_latch_go = mpc_go && (mpc_op == dram_init_pkg::MPC_CAL_LATCH);

   // header beat opens a two-beat command, next rising edge closes it
   always_comb begin
      nxt_beat = beat_ff;
      unique case (beat_ff)
         dram_init_pkg::ST_HDR: if (hdr_go) nxt_beat = dram_init_pkg::ST_ARG;
         dram_init_pkg::ST_ARG: if (arg_go) nxt_beat = dram_init_pkg::ST_HDR;
      endcase
   end

   // beat state and header fields
   always_ff @(posedge clk) begin
      if (hold_rst) begin
         beat_ff    <= dram_init_pkg::ST_HDR;
         hdr_ff     <= 5'h00;
         op7_ff     <= 1'b0;
         hdr_op6_ff <= 1'b0;
      end else begin
         beat_ff <= nxt_beat;
         if (hdr_go) begin
            hdr_ff     <= ca_s2_ff[4:0];
            hdr_op6_ff <= ca_s2_ff[5];
            if (ca_s2_ff[4:0] != dram_init_pkg::HDR_MRW2)
               op7_ff <= ca_s2_ff[5];
         end
      end
   end

   // address of a mode write is held from its first half
   always_ff @(posedge clk) begin
      if (hold_rst)
         ma_ff <= 6'h00;
      else if (mrw1_go)
         ma_ff <= ca_s2_ff;
   end

   // ==========================================
   // mode register table
   function automatic int mr_index(input logic [5:0] ma);
      unique case (ma)
         dram_init_pkg::MA_RECOVERY: mr_index = 0;
         dram_init_pkg::MA_LATENCY:  mr_index = 1;
         dram_init_pkg::MA_INVERT:   mr_index = 2;
         dram_init_pkg::MA_TERM:     mr_index = 3;
         dram_init_pkg::MA_CMD_REF:  mr_index = 4;
         dram_init_pkg::MA_SETPOINT: mr_index = 5;
         dram_init_pkg::MA_DQ_REF:   mr_index = 6;
         default:                    mr_index = dram_init_pkg::MR_COUNT;
      endcase
   endfunction : mr_index

   localparam logic [7:0] MR_RST [dram_init_pkg::MR_COUNT] = '{
      dram_init_pkg::RST_RECOVERY, dram_init_pkg::RST_LATENCY, dram_init_pkg::RST_INVERT,
      dram_init_pkg::RST_TERM, dram_init_pkg::RST_CMD_REF, dram_init_pkg::RST_SETPOINT,
      dram_init_pkg::RST_DQ_REF};
   logic [7:0] mr_ff [dram_init_pkg::MR_COUNT];
   wire  [31:0] wr_idx = mr_index(ma_ff);
   // defaults on either reset, mode write second half updates one entry
   generate
      for (genvar i = 0; i < dram_init_pkg::MR_COUNT; i++) begin : g_mr
         always_ff @(posedge clk) begin
            if (hold_rst)
               mr_ff[i] <= MR_RST[i];
            else if (mrw2_go && wr_idx == i)
               mr_ff[i] <= mrw_data;
         end
      end
   endgenerate

   // field views of the table
   assign write_recovery_cycles = mr_ff[0][dram_init_pkg::RCV_NWR_LSB +: 3];
   assign write_latency_set     = mr_ff[1][dram_init_pkg::LAT_WLS_BIT];
   assign write_latency         = mr_ff[1][dram_init_pkg::LAT_WL_LSB +: 3];
   assign read_latency          = mr_ff[1][2:0];
   assign write_level_active    = mr_ff[1][dram_init_pkg::LAT_WLEV_BIT];
   assign bus_inversion_enable  = mr_ff[2][dram_init_pkg::INV_LSB +: 2];
   assign ca_on_die_termination = mr_ff[3][dram_init_pkg::TERM_CA_LSB +: 3];
   assign dq_on_die_termination = mr_ff[3][2:0];
   assign cmd_reference_level   = mr_ff[4][dram_init_pkg::REF_RANGE:0];
   assign frequency_set_point_select = mr_ff[5][dram_init_pkg::SP_FSP_LSB +: 2];
   assign cbt_active            = mr_ff[5][dram_init_pkg::SP_CBT_BIT];
   assign dq_reference_level    = mr_ff[6][dram_init_pkg::REF_RANGE:0];

   // ==========================================
   // impedance calibration
   logic [dram_init_pkg::CAL_CNT_W-1:0] cal_cnt_ff;
   logic                                cal_busy_ff, cal_applied_ff;
   logic [CAL_W-1:0]                    drive_cal_ff;

   // start runs the timer, latch applies the code to drivers and terms
   always_ff @(posedge clk) begin
      if (hold_rst) begin
         cal_cnt_ff     <= '0;
         cal_busy_ff    <= 1'b0;
         cal_applied_ff <= 1'b0;
         drive_cal_ff   <= '0;
      end else begin
         cal_applied_ff <= cal_latch_go;
         if (cal_start_go) begin
            cal_cnt_ff  <= dram_init_pkg::CAL_CNT_W'(dram_init_pkg::CAL_CYCLES - 1);
            cal_busy_ff <= 1'b1;
         end else if (cal_cnt_ff != '0)
            cal_cnt_ff  <= cal_cnt_ff - 1'b1;
         else
            cal_busy_ff <= 1'b0;
         if (cal_latch_go)
            drive_cal_ff <= cal_code;
      end
   end
   assign cal_busy       = cal_busy_ff;
   assign cal_applied    = cal_applied_ff;
   assign drive_cal_code = drive_cal_ff;

   // ==========================================
   // data bus, array and training strobes
   logic [DQ_W-1:0] dq_ff;
   logic            oe_b_ff, ready_ff, array_ff, fwr_ff, frd_ff, rcal_ff;

   // training echoes each ca capture, free of ck alignment
   always_ff @(posedge clk) begin
      if (hold_rst) begin
         dq_ff   <= '0;
         oe_b_ff <= 1'b1;
      end else begin
         oe_b_ff <= !cbt_active;
         if (cbt_active && sample && cs_s2_ff)
            dq_ff <= DQ_W'({cs_s2_ff, ca_s2_ff});
      end
   end

   // training commands only pulse their own strobes, never the array
   always_ff @(posedge clk) begin
      if (hold_rst) begin
         ready_ff <= 1'b0;
         array_ff <= 1'b0;
         fwr_ff   <= 1'b0;
         frd_ff   <= 1'b0;
         rcal_ff  <= 1'b0;
      end else begin
         ready_ff <= cke_s2_ff;
         array_ff <= array_go && !mpc_go;
         fwr_ff   <= mpc_go && mpc_op == dram_init_pkg::MPC_FIFO_WR;
         frd_ff   <= mpc_go && mpc_op == dram_init_pkg::MPC_FIFO_RD;
         rcal_ff  <= mpc_go && mpc_op == dram_init_pkg::MPC_RD_CAL;
      end
   end
   assign dq_out        = dq_ff;
   assign dq_oe_b       = oe_b_ff;
   assign accept_ready  = ready_ff;
   assign array_cmd     = array_ff;
   assign train_fifo_wr = fwr_ff;
   assign train_fifo_rd = frd_ff;
   assign train_rd_cal  = rcal_ff;

   // ==========================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   chk_latency_default: assert property ($past(hold_rst) |-> !write_latency_set
      && write_latency == 3'h0 && read_latency == 3'h0 && write_recovery_cycles == 3'h0)
      else $error("latency defaults wrong after reset");
   chk_term_default: assert property ($past(hold_rst) |-> bus_inversion_enable == 2'h0
      && ca_on_die_termination == 3'h0 && dq_on_die_termination == 3'h0)
      else $error("inversion or termination not off after reset");
   chk_cmd_ref: assert property ($past(hold_rst) |-> cmd_reference_level == 7'h4D)
      else $error("command reference default wrong");
   chk_dq_ref: assert property ($past(hold_rst) |-> dq_reference_level == 7'h4D)
      else $error("data reference default wrong");
   chk_hiz_reset: assert property (!rstp_s2_ff |=> dq_oe_b)
      else $error("data bus driven during reset");
   chk_cal_timer: assert property (cal_start_go |=> cal_busy[*8])
      else $error("calibration ended too early");
   chk_cal_apply: assert property (cal_latch_go |=> cal_applied
      && drive_cal_code == $past(cal_code))
      else $error("latch did not apply code");
   chk_cbt_echo: assert property (cbt_active && sample && cs_s2_ff |=> ##1 !dq_oe_b
      && dq_out == DQ_W'($past({cs_s2_ff, ca_s2_ff}, 2)))
      else $error("training capture not on data bus");
   chk_wlev_entry: assert property (mrw2_go && ma_ff == dram_init_pkg::MA_LATENCY
      && mrw_data[7] |=> write_level_active)
      else $error("write leveling not entered");
   chk_cbt_entry: assert property (mrw2_go && ma_ff == dram_init_pkg::MA_SETPOINT
      |=> cbt_active == $past(mrw_data[0]))
      else $error("training mode bit not taken");
   chk_train_array: assert property (mpc_go |=> !array_cmd)
      else $error("training touched the array");
endmodule : dram_init_tracker
`default_nettype wire

// ==== verif/dram_ctrl_model.sv ====
// controller-side pin driver for the dram init tracker
// assumes the bench calls its tasks one after another, never in parallel
`timescale 1ns/1ps
`default_nettype none
module dram_ctrl_model #(
   parameter int HALF_NS = 200,
   parameter int CKE_LOW = 5000,  // low time after release, in ck cycles
   parameter int IDLE_CK = 5      // idle before first mode access
) (
   // dram pins, one channel stands for all of them
   output var logic       reset_pin_b,
   output var logic       dram_ck,
   output var logic       cke,
   output var logic       cs,
   output var logic [5:0] ca
);
   // ==========================================
   // pins start in reset while power ramps
   initial begin
      reset_pin_b = 1'b0;
      dram_ck = 1'b0;
      cke = 1'b0;
      cs = 1'b0;
      ca = 6'h00;
   end

   // boot clock runs free and stable
   always #(HALF_NS) dram_ck = ~dram_ck;

   // ==========================================
   // reset entry, clock enable, select and reset dropped together
   task automatic hold_reset(input int n);
      @(negedge dram_ck);
      cke = 1'b0;
      cs = 1'b0;
      reset_pin_b = 1'b0;
      repeat (n) @(negedge dram_ck);
   endtask : hold_reset

   // release, then wait before clock enable and first access
   task automatic release_seq();
      reset_pin_b = 1'b1;
      repeat (CKE_LOW) @(negedge dram_ck);
      cs = 1'b0;
      cke = 1'b1;
      repeat (IDLE_CK) @(negedge dram_ck);
   endtask : release_seq

   // one beat, set at falling ck, held through the rise
   task automatic beat(input logic c, input logic [5:0] v);
      @(negedge dram_ck);
      cs = c;
      ca = v;
      @(posedge dram_ck);
   endtask : beat

   task automatic cmd2(input logic [5:0] hdr, input logic [5:0] arg);
      beat(1'b1, hdr);
      beat(1'b0, arg);
   endtask : cmd2

   // mode write, two halves back to back
   task automatic mode_reg_write_cmd(input logic [5:0] addr, input logic [7:0] data);
      cmd2({data[7], dram_init_pkg::HDR_MRW1}, addr);
      cmd2({data[6], dram_init_pkg::HDR_MRW2}, data[5:0]);
   endtask : mode_reg_write_cmd

   task automatic multipurpose_cmd(input logic [6:0] op);
      cmd2({op[6], dram_init_pkg::HDR_MPC}, op[5:0]);
   endtask : multipurpose_cmd

   task automatic idle(input int n);
      repeat (n) beat(1'b0, 6'h00);
   endtask : idle

   task automatic set_cke(input logic v);
      @(negedge dram_ck);
      cke = v;
   endtask : set_cke
endmodule : dram_ctrl_model
`default_nettype wire

// ==== verif/tb.sv ====
// self-checking bench for the dram init tracker
// assumes the controller model drives all dram pins
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam int MAX_CYC = 20000;
   localparam int CAL_CK = 3;    // 1 us rounded up to ck cycles
   localparam int QUIET_CK = 8;  // larger of 30 ns and 8 cycles
   localparam logic [7:0] REF_DEF = 8'h4D; // range 1, code 001101
   logic        clk = 1'b0;
   logic        rst_b, reset_pin_b, dram_ck, cke, cs, dq_oe_b, write_latency_set;
   logic        cbt_active, write_level_active, cal_busy, cal_applied, accept_ready;
   logic        array_cmd, train_fifo_wr, train_fifo_rd, train_rd_cal;
   logic [1:0]  bus_inversion_enable, frequency_set_point_select;
   logic [2:0]  write_latency, read_latency, write_recovery_cycles;
   logic [2:0]  ca_on_die_termination, dq_on_die_termination;
   logic [5:0]  ca, cal_code, drive_cal_code;
   logic [6:0]  cmd_reference_level, dq_reference_level;
   logic [7:0]  dq_out;
   logic [6:0]  ops [3] = '{dram_init_pkg::MPC_FIFO_WR, dram_init_pkg::MPC_FIFO_RD,
                            dram_init_pkg::MPC_RD_CAL};
   logic [7:0]  exp_tr [3] = '{8'h04, 8'h06, 8'h07};
   int          fail_count = 0, num_checks = 0, cyc = 0, k = 0;
   int          n_arr = 0, n_fw = 0, n_fr = 0, n_rc = 0, n_ap = 0;

   always #25 clk = ~clk;

   dram_ctrl_model #(.CKE_LOW(8)) ctl (.reset_pin_b(reset_pin_b), .dram_ck(dram_ck),
      .cke(cke), .cs(cs), .ca(ca));

   dram_init_tracker dram_init_tracker_inst (.clk(clk), .rst_b(rst_b),
      .reset_pin_b(reset_pin_b), .dram_ck(dram_ck), .cke(cke), .cs(cs), .ca(ca),
      .cal_code(cal_code), .dq_out(dq_out), .dq_oe_b(dq_oe_b),
      .write_latency_set(write_latency_set), .write_latency(write_latency),
      .read_latency(read_latency), .write_recovery_cycles(write_recovery_cycles),
      .bus_inversion_enable(bus_inversion_enable),
      .ca_on_die_termination(ca_on_die_termination),
      .dq_on_die_termination(dq_on_die_termination),
      .cmd_reference_level(cmd_reference_level), .dq_reference_level(dq_reference_level),
      .frequency_set_point_select(frequency_set_point_select), .cbt_active(cbt_active),
      .write_level_active(write_level_active), .cal_busy(cal_busy),
      .cal_applied(cal_applied), .drive_cal_code(drive_cal_code),
      .accept_ready(accept_ready), .array_cmd(array_cmd), .train_fifo_wr(train_fifo_wr),
      .train_fifo_rd(train_fifo_rd), .train_rd_cal(train_rd_cal));

   // ==========================================
   // pulse counters and hang guard
   always @(posedge clk) begin
      cyc++;
      if (array_cmd === 1'b1) n_arr++;
      if (train_fifo_wr === 1'b1) n_fw++;
      if (train_fifo_rd === 1'b1) n_fr++;
      if (train_rd_cal === 1'b1) n_rc++;
      if (cal_applied === 1'b1) n_ap++;
      if (cyc == MAX_CYC) begin
         fail_count++;
         $display("[ERR] %0t run timed out", $time);
         conclude();
      end
   end

   // ==========================================
   // shared helpers
   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check

   task automatic settle();
      repeat (8) @(negedge clk);
   endtask : settle

   task automatic wr_mode(input logic [5:0] addr, input logic [7:0] data);
      ctl.mode_reg_write_cmd(addr, data);
      settle();
   endtask : wr_mode

   task automatic check_defaults();
      check({write_latency_set, write_latency, read_latency}, 8'h00, "latency");
      check(write_recovery_cycles, 8'h00, "recovery");
      check(bus_inversion_enable, 8'h00, "inversion");
      check({ca_on_die_termination, dq_on_die_termination}, 8'h00, "term");
      check(cmd_reference_level, REF_DEF, "cmd ref");
      check(dq_reference_level, REF_DEF, "dq ref");
      check(frequency_set_point_select, 8'h00, "set point");
   endtask : check_defaults

   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : conclude

   // ==========================================
   // test sequence
   initial begin
      rst_b = 1'b0;
      cal_code = 6'h00;
      repeat (12) @(negedge clk);
      rst_b = 1'b1;
      ctl.hold_reset(10);
      check(dq_oe_b, 8'h01, "hiz in reset");
      ctl.release_seq();
      check_defaults();
      check(accept_ready, 8'h01, "ready");
      $display("test defaults done");
      wr_mode(dram_init_pkg::MA_LATENCY, 8'h5B);
      check({write_latency_set, write_latency, read_latency}, 8'h5B, "latency");
      wr_mode(dram_init_pkg::MA_RECOVERY, 8'h50);
      check(write_recovery_cycles, 8'h05, "recovery");
      wr_mode(dram_init_pkg::MA_INVERT, 8'hC0);
      check(bus_inversion_enable, 8'h03, "inversion");
      wr_mode(dram_init_pkg::MA_TERM, 8'h35);
      check({ca_on_die_termination, dq_on_die_termination}, 8'h1D, "term");
      wr_mode(dram_init_pkg::MA_CMD_REF, 8'h2A);
      check(cmd_reference_level, 8'h2A, "cmd ref");
      wr_mode(dram_init_pkg::MA_DQ_REF, 8'h51);
      check(dq_reference_level, 8'h51, "dq ref");
      wr_mode(dram_init_pkg::MA_SETPOINT, 8'h80);
      check(frequency_set_point_select, 8'h02, "set point");
      wr_mode(6'h20, 8'h00);
      check({write_latency_set, write_latency, read_latency}, 8'h5B, "unmapped");
      $display("test mode writes done");
      ctl.multipurpose_cmd(dram_init_pkg::MPC_CAL_START);
      settle();
      check(cal_busy, 8'h01, "cal running");
      cal_code = 6'h2B;
      ctl.idle(CAL_CK);
      check(cal_busy, 8'h00, "cal finished");
      k = n_ap;
      ctl.multipurpose_cmd(dram_init_pkg::MPC_CAL_LATCH);
      settle();
      check(drive_cal_code, 8'h2B, "cal code");
      check(8'(n_ap - k), 8'h01, "latch pulse");
      ctl.idle(QUIET_CK);
      $display("test calibration done");
      wr_mode(dram_init_pkg::MA_SETPOINT, 8'h01);
      check({cbt_active, dq_oe_b}, 8'h02, "training drive");
      ctl.beat(1'b0, 6'h2A);
      settle();
      check(dq_out, 8'h00, "no capture cs low");
      ctl.beat(1'b1, 6'h2A);
      settle();
      check(dq_out, 8'h6A, "capture cs high");
      ctl.hold_reset(1);
      check({cbt_active, dq_oe_b}, 8'h01, "warm reset");
      check(dq_out, 8'h00, "warm reset data");
      ctl.release_seq();
      check_defaults();
      $display("test bus training done");
      wr_mode(dram_init_pkg::MA_LATENCY, 8'h80);
      check(write_level_active, 8'h01, "level on");
      wr_mode(dram_init_pkg::MA_LATENCY, 8'h00);
      check(write_level_active, 8'h00, "level off");
      for (int i = 0; i < 3; i++) begin
         ctl.multipurpose_cmd(ops[i]);
         ctl.cmd2(6'h12, 6'h00);
         settle();
         check(8'(n_fw * 4 + n_fr * 2 + n_rc), exp_tr[i], "training cmd");
      end
      check(8'(n_arr), 8'h00, "array untouched");
      ctl.cmd2({1'b0, dram_init_pkg::HDR_RD1}, 6'h00);
      ctl.cmd2(6'h12, 6'h00);
      settle();
      check(8'(n_arr), 8'h01, "array read");
      ctl.cmd2({1'b0, dram_init_pkg::HDR_WR1}, 6'h00);
      ctl.cmd2(6'h12, 6'h00);
      ctl.cmd2({1'b0, dram_init_pkg::HDR_MWR1}, 6'h00);
      ctl.cmd2(6'h12, 6'h00);
      ctl.cmd2(6'h01, 6'h00);
      ctl.cmd2(6'h03, 6'h00);
      settle();
      check(8'(n_arr), 8'h05, "array write and activate");
      ctl.set_cke(1'b0);
      settle();
      check(accept_ready, 8'h00, "not ready");
      wr_mode(dram_init_pkg::MA_INVERT, 8'hC0);
      check(bus_inversion_enable, 8'h00, "cke low ignored");
      ctl.set_cke(1'b1);
      $display("test training and refusal done");
      conclude();
   end
endmodule : tb
`default_nettype wire
